// ==== core/pms_power_mode_sequencer.v ====
`timescale 1ns/10ps
`include "pms_map.vh"
module pms_power_mode_sequencer #(
  parameter NPIN = 15,
  parameter [31:0] ID_VALUE = 32'h00005A5A, // Arbitrary value.
  parameter WAKE_SHDN_CYC = `PMS_WAKE_SHDN_US * `PMS_CLK_MHZ
) (
  // Clock and reset
  input  wire            pclk,
  input  wire            presetn,
  // APB slave
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [11:0]     paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output reg             pready,
  output reg             pslverr,
  // Wake and event sources
  input  wire            irq_any,
  input  wire            rtc_event,
  input  wire            sensor_event,
  input  wire            wake_pin_event,
  input  wire            reset_pin_n,
  input  wire            supply_low,
  input  wire            por_flag,
  input  wire [NPIN-1:0] gpio_out_in,
  input  wire [NPIN-1:0] gpio_pin_in,
  // Domain gating and clocks
  output reg             cpu_clk_en,
  output reg             mem_clk_en,
  output reg             periph_clk_en,
  output reg             periph_pwr_en,
  output reg             aon_pwr_en,
  output reg             sensor_pwr_en,
  output reg             sram_retain,
  output reg             flash_pwr_en,
  output reg             io_latch,
  output reg [NPIN-1:0]  gpio_out,
  output reg             hf_en,
  output reg             hf_sel_rc,
  output reg             pll_double_en,
  output reg             lf_sel_rc,
  output reg             lf_clk_out_en,
  output reg             bod_en,
  output reg             bod_lock,
  output reg             sys_reset_req,
  output reg             cpu_run,
  output reg             test_compact_sel
);

  localparam [31:0] WAKE_IDLE_CYC = `PMS_WAKE_IDLE_US * `PMS_CLK_MHZ;
  localparam [31:0] WAKE_STBY_CYC = `PMS_WAKE_STBY_US * `PMS_CLK_MHZ;

  localparam [2:0] ST_ACTIVE = 3'h0;
  localparam [2:0] ST_GATE   = 3'h1;
  localparam [2:0] ST_LOW    = 3'h2;
  localparam [2:0] ST_WAKE   = 3'h3;

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers for the single-bit event and level inputs other than irq_any and por_flag.
  reg [2:0]      wk_s_q;
  reg [2:0]      rtc_s_q;
  reg [2:0]      sen_s_q;
  reg [2:0]      rp_s_q;
  reg [2:0]      sl_s_q;

  // An edge counts only once it has reached the last two flops.
  wire           wk_ev   = wk_s_q[1] & ~wk_s_q[2];
  wire           rtc_ev  = rtc_s_q[1] & ~rtc_s_q[2];
  wire           sen_ev  = sen_s_q[1] & ~sen_s_q[2];
  wire           rp_low  = ~rp_s_q[1] & ~rp_s_q[2];
  wire           rp_fell = ~rp_s_q[1] & rp_s_q[2];
  wire           sl_now  = sl_s_q[1] & sl_s_q[2];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wk_s_q  <= 3'h0;
      rtc_s_q <= 3'h0;
      sen_s_q <= 3'h0;
      // The reset pin idles high; starting high avoids a false low.
      rp_s_q  <= 3'h7;
      sl_s_q  <= 3'h0;
    end else begin
      wk_s_q  <= {wk_s_q[1:0], wake_pin_event};
      rtc_s_q <= {rtc_s_q[1:0], rtc_event};
      sen_s_q <= {sen_s_q[1:0], sensor_event};
      rp_s_q  <= {rp_s_q[1:0], reset_pin_n};
      sl_s_q  <= {sl_s_q[1:0], supply_low};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin change detection for the shutdown wake, one slice per pin.
  wire [NPIN-1:0] pin_chg_vec;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
      reg [2:0] sync_q;
      reg       lvl_q;
      // The level is tracked all the time, so only a change made while
      // asleep is seen as a wake and not the history before entry.
      assign pin_chg_vec[gi] = (sync_q[1] == sync_q[2]) &&
                               (sync_q[2] != lvl_q);
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_q <= 3'h0;
          lvl_q  <= 1'b0;
        end else begin
          sync_q <= {sync_q[1:0], gpio_pin_in[gi]};
          if (sync_q[1] == sync_q[2])
            lvl_q <= sync_q[2];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Registers and sequencer state.
  reg [31:0]     ctrl_q;
  reg [NPIN-1:0] wpin_q;
  reg [1:0]      cause_q;
  reg [2:0]      st_q;
  reg [2:0]      mode_q;
  reg [31:0]     cnt_q;
  reg [3:0]      bod_div_q;
  reg            bod_low_q;
  reg            wake_hit;

  wire           apb_acc     = psel & penable;
  wire           apb_wr      = apb_acc & pwrite;
  wire [2:0]     req_mode    = pwdata[`PMS_CTRL_REQ_LSB+2:`PMS_CTRL_REQ_LSB];
  wire           req_low     = apb_wr && (paddr == `PMS_OFF_CTRL) &&
                               (req_mode != `PMS_MODE_ACTIVE) &&
                               (req_mode <= `PMS_MODE_HELD);
  wire           shdn_pin_wk = |(pin_chg_vec & wpin_q);
  wire           shdn_wk     = (mode_q == `PMS_MODE_SHUTDWN) &&
                               shdn_pin_wk;
  // Shutdown and held never resume: they leave through a reset.
  wire           rst_trig    = (st_q == ST_LOW) &&
                               (shdn_wk || rp_fell);

  always @* begin
    case (mode_q)
      `PMS_MODE_IDLE:    wake_hit = irq_any;
      `PMS_MODE_STANDBY: wake_hit = wk_ev | rtc_ev | sen_ev;
      default:           wake_hit = 1'b0;
    endcase
  end

  // A wake through reset clears the control and wake pin registers, as a real reset would.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `PMS_CTRL_RESET;
      wpin_q <= {NPIN{1'b0}};
    end else if (rst_trig) begin
      ctrl_q <= `PMS_CTRL_RESET;
      wpin_q <= {NPIN{1'b0}};
    end else begin
      if (apb_wr && (paddr == `PMS_OFF_CTRL))
        ctrl_q <= {24'h0, pwdata[7:4], 4'h0};
      if (apb_wr && (paddr == `PMS_OFF_WAKEPIN))
        wpin_q <= pwdata[NPIN-1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= `PMS_CAUSE_POR;
    end else if (rst_trig) begin
      if (rp_fell)
        cause_q <= `PMS_CAUSE_RSTPIN;
      else
        cause_q <= `PMS_CAUSE_PINWK;
    end else if (por_flag) begin
      cause_q <= `PMS_CAUSE_POR;
    end else if (rp_low) begin
      cause_q <= `PMS_CAUSE_RSTPIN;
    end
  end

  // Brown-out sampling only in standby: recharge slots while low, every cycle in gate and wake. A dip and a
  // release in the same cycle leave the flag set: losing a dip is worse.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bod_div_q <= 4'h0;
      bod_low_q <= 1'b0;
      bod_lock  <= 1'b0;
    end else begin
      bod_div_q <= bod_div_q + 4'h1;
      if (rp_low || por_flag) begin
        bod_low_q <= 1'b0;
        bod_lock  <= 1'b0;
      end
      if (bod_en && sl_now && (mode_q == `PMS_MODE_STANDBY))
        bod_low_q <= 1'b1;
      if ((st_q == ST_LOW) && !rst_trig && wake_hit &&
          (mode_q == `PMS_MODE_STANDBY) && bod_low_q)
        bod_lock <= 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q          <= ST_ACTIVE;
      mode_q        <= `PMS_MODE_ACTIVE;
      cnt_q         <= 32'h0;
      sys_reset_req <= 1'b0;
    end else begin
      sys_reset_req <= 1'b0;
      case (st_q)
        ST_ACTIVE: begin
          if (req_low) begin
            mode_q <= req_mode;
            st_q   <= ST_GATE;
          end
        end
        ST_GATE: begin
          st_q <= ST_LOW;
        end
        ST_LOW: begin
          if (rst_trig) begin
            sys_reset_req <= 1'b1;
            mode_q        <= `PMS_MODE_ACTIVE;
            cnt_q         <= WAKE_SHDN_CYC;
            st_q          <= ST_WAKE;
          end else if (wake_hit) begin
            if (mode_q == `PMS_MODE_IDLE)
              cnt_q <= WAKE_IDLE_CYC;
            else
              cnt_q <= WAKE_STBY_CYC;
            st_q <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (cnt_q > 32'h1) begin
            cnt_q <= cnt_q - 32'h1;
          end else if (!bod_lock) begin
            mode_q <= `PMS_MODE_ACTIVE;
            st_q   <= ST_ACTIVE;
          end
        end
        default: begin
          st_q <= ST_ACTIVE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Domain gating outputs. Each is a flop so that no glitch of the state
  // decode can reach a clock gate or a power switch.
  wire           low   = (st_q != ST_ACTIVE);
  wire           lat   = (st_q == ST_LOW) && (mode_q != `PMS_MODE_IDLE);
  wire           deep  = (mode_q == `PMS_MODE_STANDBY) ||
                         (mode_q == `PMS_MODE_SHUTDWN) ||
                         (mode_q == `PMS_MODE_HELD);
  wire           dead  = (mode_q == `PMS_MODE_SHUTDWN) ||
                         (mode_q == `PMS_MODE_HELD);
  wire           awake = (st_q == ST_ACTIVE) || !deep;
  wire           off   = (st_q == ST_LOW) && dead;

  // Clocks stop first, one cycle after the request.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en    <= 1'b1;
      mem_clk_en    <= 1'b1;
      periph_clk_en <= 1'b1;
      cpu_run       <= 1'b1;
    end else begin
      cpu_clk_en    <= !low;
      mem_clk_en    <= !low;
      periph_clk_en <= !(low && deep);
      cpu_run       <= !low;
    end
  end

  // Supplies drop only once the sequencer has settled in the mode.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_pwr_en <= 1'b1;
      aon_pwr_en    <= 1'b1;
      sensor_pwr_en <= 1'b1;
      sram_retain   <= 1'b1;
      flash_pwr_en  <= 1'b1;
      bod_en        <= 1'b1;
    end else begin
      periph_pwr_en <= !(st_q == ST_LOW && deep);
      aon_pwr_en    <= !off;
      sensor_pwr_en <= !off;
      sram_retain   <= !off;
      flash_pwr_en  <= !(st_q == ST_LOW && deep);
      if (st_q == ST_LOW && mode_q == `PMS_MODE_STANDBY)
        bod_en <= (bod_div_q < `PMS_BOD_ON);
      else
        bod_en <= !off;
    end
  end

  // Pins freeze once gating is done in every mode but idle, and thaw as the sequencer wakes.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_latch <= 1'b0;
      gpio_out <= {NPIN{1'b0}};
    end else begin
      io_latch <= lat;
      if (!lat)
        gpio_out <= gpio_out_in;
    end
  end

  // Clock sources and selections.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hf_en            <= 1'b1;
      hf_sel_rc        <= 1'b0;
      pll_double_en    <= 1'b1;
      lf_sel_rc        <= 1'b0;
      lf_clk_out_en    <= 1'b0;
      test_compact_sel <= 1'b0;
    end else begin
      hf_en            <= awake;
      hf_sel_rc        <= ctrl_q[`PMS_CTRL_HFSEL];
      pll_double_en    <= awake;
      lf_sel_rc        <= ctrl_q[`PMS_CTRL_LFSEL];
      lf_clk_out_en    <= ctrl_q[`PMS_CTRL_LFOUT];
      test_compact_sel <= ctrl_q[`PMS_CTRL_JSEL];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // APB read and answer; no wait state, always ready.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable) begin
        case (paddr)
          `PMS_OFF_CTRL:    prdata <= ctrl_q;
          `PMS_OFF_STATUS:  prdata <= {24'h0, bod_lock, cpu_run, st_q, mode_q};
          `PMS_OFF_CAUSE:   prdata <= {30'h0, cause_q};
          `PMS_OFF_WAKEPIN: prdata <= {{(32-NPIN){1'b0}}, wpin_q};
          `PMS_OFF_ID:      prdata <= ID_VALUE;
          default: begin
            prdata  <= 32'h0;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule // pms_power_mode_sequencer

// ==== dv/pms_assertions.sv ====
`timescale 1ns/10ps
module pms_assertions (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Domains
  input wire logic cpu_clk_en,
  input wire logic mem_clk_en,
  input wire logic periph_clk_en,
  input wire logic aon_pwr_en,
  input wire logic sensor_pwr_en,
  input wire logic sram_retain,
  input wire logic io_latch,
  input wire logic hf_en,
  input wire logic sys_reset_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ZERO_WAIT:
    assert property (psel && penable |-> pready) else $error("no answer");
  AST_ERR_ANSWER:
    assert property (pslverr |-> pready) else $error("error alone");
  AST_IDLE_CLK:
    assert property (cpu_clk_en == mem_clk_en) else $error("cpu mem split");
  AST_HF_OFF:
    assert property (!periph_clk_en [*2] |-> !hf_en) else $error("hf on");
  AST_AON_OFF:
    assert property (!aon_pwr_en |-> !sensor_pwr_en && !sram_retain)
      else $error("power left on");
  AST_STBY:
    assert property (!periph_clk_en [*2] |-> !cpu_clk_en)
      else $error("cpu clocked");
  AST_GATE_FIRST:
    assert property ($rose(io_latch) |-> !cpu_clk_en && $past(!cpu_clk_en))
      else $error("latch before gate");
  AST_RST_PULSE:
    assert property (sys_reset_req |=> !sys_reset_req) else $error("long");
  cover property ($rose(io_latch));
  cover property (sys_reset_req);
  cover property (pslverr);
endmodule // pms_assertions

bind pms_power_mode_sequencer pms_assertions i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .cpu_clk_en(cpu_clk_en),
  .mem_clk_en(mem_clk_en), .periph_clk_en(periph_clk_en),
  .aon_pwr_en(aon_pwr_en), .sensor_pwr_en(sensor_pwr_en),
  .sram_retain(sram_retain), .io_latch(io_latch), .hf_en(hf_en),
  .sys_reset_req(sys_reset_req));

// ==== dv/pms_wake_src.sv ====
`timescale 1ns/10ps
module pms_wake_src (
  // Clock and command
  input wire logic       pclk,
  input wire logic [2:0] kick,
  // Events
  output logic           rtc_event,
  output logic           sensor_event,
  output logic           wake_pin_event
);
  logic [2:0] ev_q = 3'h0;
  logic [3:0] cnt_q = 4'h0;
  // Events are held well past the three-flop synchroniser of the block.
  always @(posedge pclk) begin
    if (kick != 3'h0) begin
      ev_q <= kick;
      cnt_q <= 4'h8;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else begin
      ev_q <= 3'h0;
    end
  end
  assign {wake_pin_event, sensor_event, rtc_event} = ev_q;
endmodule // pms_wake_src

// ==== dv/tb.sv ====
`timescale 1ns/10ps
`include "pms_map.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        err, irq_any, reset_pin_n, rtc_event, sensor_event;
  logic        wake_pin_event, cpu_run, cpu_clk_en, mem_clk_en;
  logic        periph_clk_en, periph_pwr_en, aon_pwr_en, io_latch;
  logic        hf_sel_rc, lf_sel_rc, lf_clk_out_en, test_compact_sel;
  logic        pll_double_en;
  logic        supply_low, por_flag, sensor_pwr_en, sram_retain;
  logic        flash_pwr_en, hf_en, bod_en, bod_lock;
  logic [2:0]  kick;
  logic [14:0] gpio_out_in, gpio_pin_in, gpio_out;
  int          fails = 0;
  int          checks_done = 0;
  pms_power_mode_sequencer #(.WAKE_SHDN_CYC(20)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq_any, .rtc_event, .sensor_event,
    .wake_pin_event, .reset_pin_n, .supply_low, .por_flag,
    .gpio_out_in, .gpio_pin_in, .cpu_clk_en, .mem_clk_en, .periph_clk_en,
    .periph_pwr_en, .aon_pwr_en, .sensor_pwr_en, .sram_retain,
    .flash_pwr_en, .io_latch, .gpio_out, .hf_en, .hf_sel_rc,
    .pll_double_en, .lf_sel_rc, .lf_clk_out_en, .bod_en, .bod_lock,
    .sys_reset_req(), .cpu_run, .test_compact_sel);
  pms_wake_src i_src (.pclk, .kick, .rtc_event, .sensor_event,
    .wake_pin_event);
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Look at the settled answer ahead of the edge that completes it.
    @(negedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 20) fails++;
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_run(input logic v, input int lim);
    int n;
    n = 0;
    while (cpu_run !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    repeat (3) @(posedge pclk);
  endtask
  task automatic t_regs;
    apb(1'b0, `PMS_OFF_CTRL, 32'h0);
    `CHK(rd, `PMS_CTRL_RESET)
    `CHK(pll_double_en, 1'b1)
    apb(1'b0, 12'h7F0, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
  endtask
  task automatic t_idle;
    apb(1'b1, `PMS_OFF_CTRL, 32'h1);
    wait_run(1'b0, 20);
    `CHK({cpu_clk_en, mem_clk_en, periph_clk_en}, 3'h1)
    irq_any <= 1'b1;
    wait_run(1'b1, 400);
    irq_any <= 1'b0;
    `CHK(cpu_run, 1'b1)
  endtask
  task automatic t_standby;
    int ones;
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, `PMS_OFF_CTRL, 32'hF2);
      wait_run(1'b0, 20);
      `CHK({aon_pwr_en, periph_pwr_en, io_latch}, 3'h5)
      `CHK({flash_pwr_en, hf_en, sensor_pwr_en}, 3'h1)
      ones = 0;
      repeat (16) begin
        @(negedge pclk);
        ones += bod_en;
      end
      @(posedge pclk);
      `CHK(ones, 2)
      irq_any <= 1'b1;
      repeat (50) @(posedge pclk);
      irq_any <= 1'b0;
      `CHK(cpu_run, 1'b0)
      kick <= 3'h1 << k;
      @(posedge pclk);
      kick <= 3'h0;
      wait_run(1'b1, 4000);
      `CHK(cpu_run, 1'b1)
      apb(1'b0, `PMS_OFF_CTRL, 32'h0);
      `CHK(rd, 32'hF0)
      `CHK({hf_sel_rc, lf_sel_rc, lf_clk_out_en, test_compact_sel}, 4'hF)
    end
  endtask
  task automatic t_shutdown;
    gpio_out_in <= 15'h2A5A;
    apb(1'b1, `PMS_OFF_WAKEPIN, 32'h1);
    apb(1'b1, `PMS_OFF_CTRL, 32'hF3);
    wait_run(1'b0, 20);
    gpio_out_in <= 15'h55A5;
    repeat (5) @(posedge pclk);
    `CHK({aon_pwr_en, io_latch, gpio_out}, {2'h1, 15'h2A5A})
    `CHK({sensor_pwr_en, sram_retain, flash_pwr_en, hf_en, bod_en}, 5'h0)
    gpio_pin_in <= 15'h1;
    wait_run(1'b1, 200);
    apb(1'b0, `PMS_OFF_CAUSE, 32'h0);
    `CHK(rd[1:0], `PMS_CAUSE_PINWK)
    apb(1'b0, `PMS_OFF_CTRL, 32'h0);
    `CHK(rd, 32'h0)
  endtask
  task automatic t_held;
    apb(1'b1, `PMS_OFF_WAKEPIN, 32'h1);
    apb(1'b1, `PMS_OFF_CTRL, 32'h4);
    wait_run(1'b0, 20);
    gpio_pin_in <= 15'h0;
    repeat (60) @(posedge pclk);
    `CHK(cpu_run, 1'b0)
    reset_pin_n <= 1'b0;
    repeat (4) @(posedge pclk);
    reset_pin_n <= 1'b1;
    wait_run(1'b1, 200);
    apb(1'b0, `PMS_OFF_CAUSE, 32'h0);
    `CHK(rd[1:0], `PMS_CAUSE_RSTPIN)
  endtask
  task automatic t_bod;
    apb(1'b1, `PMS_OFF_CTRL, 32'h2);
    wait_run(1'b0, 20);
    supply_low <= 1'b1;
    repeat (40) @(posedge pclk);
    supply_low <= 1'b0;
    kick <= 3'h1;
    @(posedge pclk);
    kick <= 3'h0;
    repeat (3900) @(posedge pclk);
    `CHK({cpu_run, bod_lock}, 2'h1)
    reset_pin_n <= 1'b0;
    repeat (4) @(posedge pclk);
    reset_pin_n <= 1'b1;
    wait_run(1'b1, 20);
    `CHK({cpu_run, bod_lock}, 2'h2)
    apb(1'b0, `PMS_OFF_CAUSE, 32'h0);
    `CHK(rd[1:0], `PMS_CAUSE_RSTPIN)
    por_flag <= 1'b1;
    @(posedge pclk);
    por_flag <= 1'b0;
    apb(1'b0, `PMS_OFF_CAUSE, 32'h0);
    `CHK(rd[1:0], `PMS_CAUSE_POR)
  endtask
  task automatic wrap_up;
    if (fails == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, irq_any, kick} = 8'h0;
    {reset_pin_n, paddr, pwdata} = {1'b1, 44'h0};
    {gpio_out_in, gpio_pin_in} = 30'h0;
    {supply_low, por_flag} = 2'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_idle;
    t_standby;
    t_shutdown;
    t_held;
    t_bod;
    wrap_up;
  end
  // Four standby wakes dominate the run; this leaves ample margin.
  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    wrap_up;
  end
endmodule // tb

// ==== include/pms_map.vh ====
`ifndef PMS_MAP_VH
`define PMS_MAP_VH
`define PMS_OFF_CTRL    12'h000
`define PMS_OFF_STATUS  12'h004
`define PMS_OFF_CAUSE   12'h008
`define PMS_OFF_WAKEPIN 12'h00C
`define PMS_OFF_ID      12'h010
`define PMS_CTRL_REQ_LSB 0
`define PMS_CTRL_HFSEL   4
`define PMS_CTRL_LFSEL   5
`define PMS_CTRL_LFOUT   6
`define PMS_CTRL_JSEL    7
`define PMS_CTRL_RESET   32'h00000000
`define PMS_MODE_ACTIVE  3'h0
`define PMS_MODE_IDLE    3'h1
`define PMS_MODE_STANDBY 3'h2
`define PMS_MODE_SHUTDWN 3'h3
`define PMS_MODE_HELD    3'h4
`define PMS_CAUSE_POR    2'h0
`define PMS_CAUSE_RSTPIN 2'h1
`define PMS_CAUSE_PINWK  2'h2
`define PMS_CLK_MHZ      25
`define PMS_WAKE_IDLE_US 14
`define PMS_WAKE_STBY_US 151
`define PMS_WAKE_SHDN_US 1015
`define PMS_BOD_PERIOD   16
`define PMS_BOD_ON       2
`endif
